/* File: pds_pkg.sv */
// Package: constants, register map and types for the PWM dead-band and steering stage
//
// Notes on behaviour
// - Non-listed three-phase code: lowest set bit wins
// - High-side enable modulates active high output
// - Low-side enable modulates active low output
// - Both enables clear: hold rising-event states
// - Rising event activates, falling event deactivates outputs
// - Two independent 8-bit dead-band counters
// - Rising event delays primary turn-on
// - Falling event delays complementary turn-on
// - New dead times load at period after strobe
// - Dead-band enables act immediately
// - Counters advance every PWM clock edge
// - Asynchronous events may add one clock
// - Falling during rising count: switch, suppress primary
// - Rising during falling count: switch, suppress complementary
// - Same-edge repeat restarts count, freezes outputs
// - Synchronized steering waits for period after strobe
// - Steering only in single, complementary, three-phase
// - Single mode: signal to any pin combination
// - Complementary mode: primary only to A, C, E
// - Complementary mode: complement only to B, D, E; code drives it to B and D only, E always carries the primary
// - Dead band only in complementary and bridge modes
// - Three-phase codes drive one high, one low pair
// - Synchronized steering only while sync bit set
package pds_pkg;

  // ==========================================================
  // Register map (byte addresses, one word each)
  localparam logic [7:0] PDS_ADDR_MAIN_CTRL  = 8'h00;
  localparam logic [7:0] PDS_ADDR_STEER_SEL  = 8'h04;
  localparam logic [7:0] PDS_ADDR_STEER_CTRL = 8'h08;
  localparam logic [7:0] PDS_ADDR_RISE_DT    = 8'h0c;
  localparam logic [7:0] PDS_ADDR_FALL_DT    = 8'h10;
  localparam logic [7:0] PDS_ADDR_LOAD       = 8'h14;
  localparam logic [7:0] PDS_ADDR_STATUS     = 8'h18;

  // ==========================================================
  // Field positions
  localparam int PDS_CTRL_EN_BIT    = 0;
  localparam int PDS_CTRL_DBRE_BIT  = 1;
  localparam int PDS_CTRL_DBFE_BIT  = 2;
  localparam int PDS_CTRL_MODE_LSB  = 4;
  localparam int PDS_SCTL_SYNC_BIT  = 0;
  localparam int PDS_SCTL_HSM_BIT   = 1;
  localparam int PDS_SCTL_LSM_BIT   = 2;
  localparam int PDS_LOAD_BIT       = 0;
  localparam int PDS_STAT_RCNT_BIT  = 8;
  localparam int PDS_STAT_FCNT_BIT  = 9;
  localparam int PDS_STAT_FRZ_BIT   = 10;
  localparam int PDS_STAT_LOAD_BIT  = 11;
  localparam int PDS_STAT_MODE_LSB  = 12;
  localparam int PDS_STAT_STEER_LSB = 16;

  // ==========================================================
  // Widths and reset values
  localparam int          PDS_DT_W          = 8;
  localparam int          PDS_STEER_W       = 6;
  localparam int          PDS_MODE_W        = 3;
  localparam logic [31:0] PDS_CTRL_RESET    = 32'h0000_0000;
  localparam logic [5:0]  PDS_STEER_RESET   = 6'h00;
  localparam logic [7:0]  PDS_DT_RESET      = 8'h00;
  localparam logic [31:0] PDS_RDATA_UNMAP   = 32'h0000_0000;

  // ==========================================================
  // Modes, index of pin in steering vector: A=0 .. F=5
  typedef enum logic [2:0] {
    PDS_MODE_SINGLE = 3'h0,
    PDS_MODE_COMP   = 3'h1,
    PDS_MODE_3PH    = 3'h2,
    PDS_MODE_FBRIDGE = 3'h3,
    PDS_MODE_OTHER  = 3'h4
  } pds_mode_e;

  localparam logic [5:0] PDS_PRI_PINS  = 6'h15;  // A, C, E
  localparam logic [5:0] PDS_COMP_PINS = 6'h1a;  // B, D, E

  // Three-phase pin pairs per one-hot code, bit order F..A
  localparam logic [5:0] PDS_3PH_S1 = 6'h09;  // A, D
  localparam logic [5:0] PDS_3PH_S2 = 6'h21;  // A, F
  localparam logic [5:0] PDS_3PH_S3 = 6'h24;  // C, F
  localparam logic [5:0] PDS_3PH_S4 = 6'h06;  // C, B
  localparam logic [5:0] PDS_3PH_S5 = 6'h12;  // E, B
  localparam logic [5:0] PDS_3PH_S6 = 6'h18;  // E, D
  localparam logic [5:0] PDS_HIGH_PINS = 6'h15;  // A, C, E
  localparam logic [5:0] PDS_LOW_PINS  = 6'h2a;  // B, D, F

endpackage

/* File: pds_db_if.sv */
// Interface: event and timing link between the steering stage and one dead-band counter
`timescale 1ns/1ps
`default_nettype none
interface pds_db_if;
  logic       start;
  logic       stop;
  logic [7:0] limit;
  logic       busy;
  logic       done;
  modport ctrl (output start, output stop, output limit, input busy, input done);
  modport cnt  (input start, input stop, input limit, output busy, output done);
endinterface
`default_nettype wire

/* File: pds_deadband_counter.sv */
// Module: one 8-bit dead-band interval counter
`timescale 1ns/1ps
`default_nettype none
module pds_deadband_counter
  import pds_pkg::*;
(
  // Clock, reset, enable
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  // Control link
  pds_db_if.cnt     db
);
  logic [PDS_DT_W-1:0] count;
  logic                done_q;

  assign db.done = done_q;

  // Start restarts from zero even when already running
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count   <= '0;
      db.busy <= 1'b0;
      done_q  <= 1'b0;
    end else if (ce) begin
      done_q <= 1'b0;
      if (db.start) begin
        count   <= '0;
        db.busy <= 1'b1;
      end else if (db.stop) begin
        db.busy <= 1'b0;
      end else if (db.busy) begin
        if (count >= db.limit) begin
          db.busy <= 1'b0;
          done_q  <= 1'b1;
        end else begin
          count <= count + 8'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: pds_top.sv */
// Module: dead-band generation and output steering stage with APB registers
//
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module pds_top
  import pds_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // PWM events
  input  wire logic        rise_event,
  input  wire logic        fall_event,
  input  wire logic        period_event,
  // Output pins
  output logic             out_a,
  output logic             out_b,
  output logic             out_c,
  output logic             out_d,
  output logic             out_e,
  output logic             out_f
);
  import pds_pkg::*;

  // ==========================================================
  // Registers
  logic [31:0]            main_ctrl_reg;
  logic [PDS_STEER_W-1:0] steer_select_reg;
  logic [2:0]             steer_ctrl_reg;
  logic [PDS_DT_W-1:0]    rise_deadtime_reg;
  logic [PDS_DT_W-1:0]    fall_deadtime_reg;
  logic                   load_strobe;
  logic [PDS_DT_W-1:0]    rise_dt_act;
  logic [PDS_DT_W-1:0]    fall_dt_act;
  logic [PDS_STEER_W-1:0] steer_buf;

  logic      module_en;
  logic      rise_deadband_en;
  logic      fall_deadband_en;
  logic      steer_sync_en;
  logic      high_side_mod_en;
  logic      low_side_mod_en;
  pds_mode_e mode;

  assign module_en        = main_ctrl_reg[PDS_CTRL_EN_BIT];
  assign rise_deadband_en = main_ctrl_reg[PDS_CTRL_DBRE_BIT];
  assign fall_deadband_en = main_ctrl_reg[PDS_CTRL_DBFE_BIT];
  assign mode             = pds_mode_e'(main_ctrl_reg[PDS_CTRL_MODE_LSB +: PDS_MODE_W]);
  assign steer_sync_en    = steer_ctrl_reg[PDS_SCTL_SYNC_BIT];
  assign high_side_mod_en = steer_ctrl_reg[PDS_SCTL_HSM_BIT];
  assign low_side_mod_en  = steer_ctrl_reg[PDS_SCTL_LSM_BIT];

  // ==========================================================
  // APB access, zero wait states
  logic wr_acc;
  logic rd_acc;
  logic addr_ok;
  logic en_rise;

  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && !penable && !pwrite;
  assign addr_ok = (paddr == PDS_ADDR_MAIN_CTRL) || (paddr == PDS_ADDR_STEER_SEL)
                || (paddr == PDS_ADDR_STEER_CTRL) || (paddr == PDS_ADDR_RISE_DT)
                || (paddr == PDS_ADDR_FALL_DT) || (paddr == PDS_ADDR_LOAD)
                || (paddr == PDS_ADDR_STATUS);
  assign en_rise = wr_acc && (paddr == PDS_ADDR_MAIN_CTRL)
                && pwdata[PDS_CTRL_EN_BIT] && !module_en;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_ctrl_reg     <= PDS_CTRL_RESET;
      steer_select_reg  <= PDS_STEER_RESET;
      steer_ctrl_reg    <= '0;
      rise_deadtime_reg <= PDS_DT_RESET;
      fall_deadtime_reg <= PDS_DT_RESET;
    end else if (ce && wr_acc) begin
      case (paddr)
        PDS_ADDR_MAIN_CTRL:  main_ctrl_reg     <= pwdata;
        PDS_ADDR_STEER_SEL:  steer_select_reg  <= pwdata[PDS_STEER_W-1:0];
        PDS_ADDR_STEER_CTRL: steer_ctrl_reg    <= pwdata[2:0];
        PDS_ADDR_RISE_DT:    rise_deadtime_reg <= pwdata[PDS_DT_W-1:0];
        PDS_ADDR_FALL_DT:    fall_deadtime_reg <= pwdata[PDS_DT_W-1:0];
        default: ;
      endcase
    end
  end

  // Pending load: period event clears it, but a fresh strobe wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_strobe <= 1'b0;
    end else if (ce) begin
      if (wr_acc && (paddr == PDS_ADDR_LOAD) && pwdata[PDS_LOAD_BIT]) begin
        load_strobe <= 1'b1;
      end else if (period_event) begin
        load_strobe <= 1'b0;
      end
    end
  end

  // Active dead times and steering buffer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rise_dt_act <= PDS_DT_RESET;
      fall_dt_act <= PDS_DT_RESET;
      steer_buf   <= PDS_STEER_RESET;
    end else if (ce) begin
      if (!module_en) begin
        // Idle module tracks writes directly
        rise_dt_act <= rise_deadtime_reg;
        fall_dt_act <= fall_deadtime_reg;
      end else if (load_strobe && period_event) begin
        rise_dt_act <= rise_deadtime_reg;
        fall_dt_act <= fall_deadtime_reg;
      end
      // Buffer preloads on enable or strobe, even without sync
      // Strobe preload while synced would bypass the period wait
      if (en_rise || (wr_acc && (paddr == PDS_ADDR_LOAD) && pwdata[PDS_LOAD_BIT]
                      && !(steer_sync_en && module_en))) begin
        steer_buf <= steer_select_reg;
      end else if (load_strobe && period_event) begin
        steer_buf <= steer_select_reg;
      end
    end
  end

  // Sync only applies with sync bit set and module running
  logic [PDS_STEER_W-1:0] steer_eff;
  assign steer_eff = (steer_sync_en && module_en) ? steer_buf : steer_select_reg;

  // ==========================================================
  // Base PWM level from events
  logic base_pwm;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_pwm <= 1'b0;
    end else if (ce) begin
      if (!module_en) begin
        base_pwm <= 1'b0;
      end else if (rise_event) begin
        base_pwm <= 1'b1;
      end else if (fall_event) begin
        base_pwm <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Dead-band sequencing
  pds_db_if rise_db ();
  pds_db_if fall_db ();

  pds_deadband_counter u_rise_cnt (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .db      (rise_db.cnt)
  );

  pds_deadband_counter u_fall_cnt (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .db      (fall_db.cnt)
  );

  logic db_mode;
  logic rise_go;
  logic fall_go;
  logic frozen;
  logic pri_q;
  logic comp_q;

  // Event inputs are sampled synchronously; async sources add up to one clock
  assign db_mode = module_en && ((mode == PDS_MODE_COMP) || (mode == PDS_MODE_FBRIDGE));
  assign rise_go = db_mode && rise_deadband_en && rise_event;
  assign fall_go = db_mode && fall_deadband_en && fall_event && !rise_event;

  assign rise_db.start = rise_go;
  assign fall_db.start = fall_go;
  assign rise_db.stop  = fall_event || !rise_deadband_en;
  assign fall_db.stop  = rise_event || !fall_deadband_en;
  assign rise_db.limit = rise_dt_act;
  assign fall_db.limit = fall_dt_act;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frozen <= 1'b0;
      pri_q  <= 1'b0;
      comp_q <= 1'b0;
    end else if (ce) begin
      if (!db_mode) begin
        frozen <= 1'b0;
        pri_q  <= base_pwm;
        comp_q <= !base_pwm;
      end else begin
        if ((rise_go && rise_db.busy) || (fall_go && fall_db.busy)) begin
          frozen <= 1'b1;
        end else if (rise_db.done || fall_db.done || rise_event || fall_event) begin
          frozen <= 1'b0;
        end
        if (rise_event) begin
          comp_q <= 1'b0;
          pri_q  <= !rise_deadband_en;
        end else if (fall_event) begin
          pri_q  <= 1'b0;
          comp_q <= !fall_deadband_en;
        end else if (frozen && (rise_db.busy || fall_db.busy)) begin
          pri_q  <= pri_q;
          comp_q <= comp_q;
        end else if (rise_db.done) begin
          pri_q <= base_pwm;
        end else if (fall_db.done) begin
          comp_q <= !base_pwm;
        end else if (!rise_db.busy && !fall_db.busy) begin
          pri_q  <= base_pwm;
          comp_q <= !base_pwm;
        end
      end
    end
  end

  // ==========================================================
  // Three-phase pair selection, lowest set bit wins
  logic [5:0] ph_pins;
  always_comb begin
    ph_pins = '0;
    if (steer_eff[0]) begin
      ph_pins = PDS_3PH_S1;
    end else if (steer_eff[1]) begin
      ph_pins = PDS_3PH_S2;
    end else if (steer_eff[2]) begin
      ph_pins = PDS_3PH_S3;
    end else if (steer_eff[3]) begin
      ph_pins = PDS_3PH_S4;
    end else if (steer_eff[4]) begin
      ph_pins = PDS_3PH_S5;
    end else if (steer_eff[5]) begin
      ph_pins = PDS_3PH_S6;
    end
  end

  // ==========================================================
  // Output steering
  logic [5:0] next_pins;
  logic       hi_lvl;
  logic       lo_lvl;
  always_comb begin
    next_pins = '0;
    // Unmodulated side sits at its rising-event (active) state
    hi_lvl = high_side_mod_en ? base_pwm : !low_side_mod_en || 1'b1;
    lo_lvl = low_side_mod_en  ? base_pwm : 1'b1;
    if (!high_side_mod_en && !low_side_mod_en) begin
      hi_lvl = 1'b1;
      lo_lvl = 1'b1;
    end
    case (mode)
      PDS_MODE_SINGLE: begin
        next_pins = steer_eff & {6{base_pwm}};
      end
      PDS_MODE_COMP: begin
        // Shared pin E carries the primary when both are steered there
        next_pins = (steer_eff & PDS_PRI_PINS & {6{pri_q}})
                  | (steer_eff & PDS_COMP_PINS & ~PDS_PRI_PINS & {6{comp_q}});
      end
      PDS_MODE_3PH: begin
        next_pins = (ph_pins & PDS_HIGH_PINS & {6{hi_lvl}})
                  | (ph_pins & PDS_LOW_PINS & {6{lo_lvl}});
      end
      PDS_MODE_FBRIDGE: begin
        // No steering here: fixed primary/complementary pair
        next_pins = {4'h0, comp_q, pri_q};
      end
      default: next_pins = '0;
    endcase
    if (!module_en) begin
      next_pins = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {out_f, out_e, out_d, out_c, out_b, out_a} <= 6'h00;
    end else if (ce) begin
      {out_f, out_e, out_d, out_c, out_b, out_a} <= next_pins;
    end
  end

  // ==========================================================
  // Read data registered in setup phase
  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = PDS_RDATA_UNMAP;
    case (paddr)
      PDS_ADDR_MAIN_CTRL:  next_rdata = main_ctrl_reg;
      PDS_ADDR_STEER_SEL:  next_rdata = {26'h0, steer_select_reg};
      PDS_ADDR_STEER_CTRL: next_rdata = {29'h0, steer_ctrl_reg};
      PDS_ADDR_RISE_DT:    next_rdata = {24'h0, rise_deadtime_reg};
      PDS_ADDR_FALL_DT:    next_rdata = {24'h0, fall_deadtime_reg};
      PDS_ADDR_LOAD:       next_rdata = {31'h0, load_strobe};
      PDS_ADDR_STATUS: begin
        next_rdata = PDS_RDATA_UNMAP;
        next_rdata[5:0] = {out_f, out_e, out_d, out_c, out_b, out_a};
        next_rdata[PDS_STAT_RCNT_BIT] = rise_db.busy;
        next_rdata[PDS_STAT_FCNT_BIT] = fall_db.busy;
        next_rdata[PDS_STAT_FRZ_BIT]  = frozen;
        next_rdata[PDS_STAT_LOAD_BIT] = load_strobe;
        next_rdata[PDS_STAT_MODE_LSB +: PDS_MODE_W] = mode;
        next_rdata[PDS_STAT_STEER_LSB +: PDS_STEER_W] = steer_eff;
      end
      default: next_rdata = PDS_RDATA_UNMAP;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      if (rd_acc) begin
        prdata <= next_rdata;
      end
    end
  end
endmodule
`default_nettype wire

/* File: pds_top_monitor.sv */
// Checker: port-level assertions for the dead-band and steering stage
`timescale 1ns/1ps
`default_nettype none
module pds_top_monitor
  import pds_pkg::*;
(
  // Clock, reset, enable
  input wire logic        pclk, presetn, ce,
  // APB
  input wire logic        psel, penable, pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic        pready, pslverr,
  // Events and pins
  input wire logic        rise_event, fall_event, period_event,
  input wire logic        out_a, out_b, out_c, out_d, out_e, out_f
);
  logic [5:0] pins, steer;
  logic [2:0] mode, stab, sctl;
  logic [7:0] rdt_n, fdt_n, rdt, fdt, rcnt, fcnt;
  logic       en, dbre, dbfe, pend, wr, cmp, thr;
  assign pins = {out_f, out_e, out_d, out_c, out_b, out_a};
  assign wr = psel && penable && pready && pwrite;
  assign cmp = mode == PDS_MODE_COMP && en && stab == 3'h7;
  assign thr = mode == PDS_MODE_3PH && en && stab == 3'h7 && !sctl[0];
  // ==========================================
  // Shadow of the software settings
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {mode, dbfe, dbre, en, steer, sctl, stab} <= '0;
    end else begin
      if (wr && paddr == PDS_ADDR_MAIN_CTRL) {mode, dbfe, dbre, en} <= {pwdata[6:4], pwdata[2:0]};
      if (wr && paddr == PDS_ADDR_STEER_SEL) steer <= pwdata[5:0];
      if (wr && paddr == PDS_ADDR_STEER_CTRL) sctl <= pwdata[2:0];
      if (wr && paddr <= PDS_ADDR_STEER_CTRL) stab <= 3'h0;
      else if (stab != 3'h7) stab <= stab + 3'h1;
    end
  end
  // Staged dead times follow the load strobe only while enabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {rdt_n, fdt_n, rdt, fdt, pend} <= '0;
    end else begin
      if (wr && paddr == PDS_ADDR_RISE_DT) rdt_n <= pwdata[7:0];
      if (wr && paddr == PDS_ADDR_FALL_DT) fdt_n <= pwdata[7:0];
      if (!en || (period_event && pend)) {rdt, fdt} <= {rdt_n, fdt_n};
      if (wr && paddr == PDS_ADDR_LOAD && pwdata[0]) pend <= 1'b1;
      else if (period_event && en) pend <= 1'b0;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {rcnt, fcnt} <= 16'hffff;
    end else begin
      rcnt <= rise_event ? 8'h00 : rcnt + {7'h0, rcnt != 8'hff};
      fcnt <= fall_event ? 8'h00 : fcnt + {7'h0, fcnt != 8'hff};
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_bus_answer: assert property (psel && !penable && ce |=> pready)
    else $error("access phase not answered at once");
  a_bad_addr: assert property (psel && penable && pready |-> pslverr == (paddr > 8'h18 || paddr[1:0] != 2'h0))
    else $error("error response does not match address");
  a_reset_quiet: assert property ($rose(presetn) |-> pins == 6'h00)
    else $error("pins active right after reset");
  a_rise_dead: assert property ($rose(out_a) && cmp && dbre |-> rcnt > rdt)
    else $error("primary on before rise dead time");
  a_fall_dead: assert property ($rose(out_b) && cmp && dbfe |-> fcnt > fdt)
    else $error("complement on before fall dead time");
  a_no_overlap: assert property (cmp |-> !(out_a && out_b))
    else $error("primary and complement both on");
  a_fall_drops: assert property (fall_event && cmp |-> ##[1:4] !out_a)
    else $error("primary still on after falling event");
  a_steer_mask: assert property ((mode == PDS_MODE_SINGLE || cmp) && en && stab == 3'h7 && !sctl[0] |-> (pins & ~steer) == 6'h00)
    else $error("unsteered pin active");
  a_phase_short: assert property (thr |-> !(out_a && out_b) && !(out_c && out_d) && !(out_e && out_f))
    else $error("both sides of one phase on");
  a_phase_hold: assert property (thr && sctl[2:1] == 2'h0 && steer == 6'h01 |-> pins == 6'h09)
    else $error("unmodulated phase pair not held");
  c_rise_dead: cover property ($rose(out_a) && cmp && dbre);
  c_phase: cover property (thr && pins == 6'h18);
  c_bad_addr: cover property (pready && pslverr);
endmodule

bind pds_top pds_top_monitor u_mon (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .rise_event(rise_event), .fall_event(fall_event),
  .period_event(period_event), .out_a(out_a), .out_b(out_b), .out_c(out_c), .out_d(out_d),
  .out_e(out_e), .out_f(out_f));
`default_nettype wire

/* File: pds_bridge_model.sv */
// Model: one half-bridge driver pair fed by a primary and a complementary pin
`timescale 1ns/1ps
`default_nettype none
module pds_bridge_model (
  // Clock and clear
  input  wire logic       pclk,
  input  wire logic       clr,
  // Gate pins
  input  wire logic       hi_gate,
  input  wire logic       lo_gate,
  // Observations
  output logic      [7:0] gap_hi,
  output logic      [7:0] gap_lo,
  output logic            shoot
);
  logic [7:0] idle;
  logic       hi_q, lo_q;
  // Both switches on at once would short the supply rail
  always_ff @(posedge pclk) begin
    hi_q <= hi_gate;
    lo_q <= lo_gate;
    idle <= (clr || hi_gate || lo_gate) ? 8'h00 : idle + 8'h01;
    if (hi_gate && !hi_q) gap_hi <= idle;
    if (lo_gate && !lo_q) gap_lo <= idle;
    shoot <= !clr && (shoot || (hi_gate && lo_gate));
  end
endmodule
`default_nettype wire

/* File: test_pds_top.sv */
// Testbench: directed scenarios for the dead-band and steering stage
`timescale 1ns/1ps
`default_nettype none
module test_pds_top;
  import pds_pkg::*;
  localparam logic [35:0] EXP3 = {6'h18, 6'h12, 6'h06, 6'h24, 6'h21, 6'h09};
  logic        pclk = 1'b0, presetn = 1'b0, ce = 1'b1, clr = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, gap_hi, gap_lo;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err, shoot;
  logic        rise_event = 1'b0, fall_event = 1'b0, period_event = 1'b0;
  logic        out_a, out_b, out_c, out_d, out_e, out_f;
  logic [5:0]  pins;
  logic [1:0]  s;
  int          fails = 0, total_checks = 0;
  assign pins = {out_f, out_e, out_d, out_c, out_b, out_a};
  always #4 pclk = ~pclk;
  pds_top u_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rise_event(rise_event), .fall_event(fall_event),
    .period_event(period_event), .out_a(out_a), .out_b(out_b), .out_c(out_c),
    .out_d(out_d), .out_e(out_e), .out_f(out_f));
  pds_bridge_model u_drv (.pclk(pclk), .clr(clr), .hi_gate(out_a), .lo_gate(out_b),
    .gap_hi(gap_hi), .gap_lo(gap_lo), .shoot(shoot));
  // ==========================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (n >= 40) begin
      fails++;
      stop_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic ctl(input logic [2:0] m, input logic re, fe, e);
    wr(PDS_ADDR_MAIN_CTRL, {25'h0, m, 1'b0, fe, re, e});
  endtask
  // Kind 0 rising, 1 falling, 2 period
  task automatic pulse(input int k);
    @(posedge pclk);
    rise_event <= (k == 0);
    fall_event <= (k == 1);
    period_event <= (k == 2);
    @(posedge pclk);
    {rise_event, fall_event, period_event} <= 3'b000;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic watch(input int n);
    s = 2'b00;
    repeat (n) begin
      @(posedge pclk);
      s = s | {out_b, out_a};
    end
  endtask
  // ==========================================
  // Scenarios
  task automatic t_regs;
    apb(1'b0, PDS_ADDR_MAIN_CTRL, 32'h0);
    check(rd, PDS_CTRL_RESET);
    wr(8'h40, 32'hffff_ffff);
    check(err, 1'b1);
    apb(1'b0, 8'h40, 32'h0);
    check(rd, PDS_RDATA_UNMAP);
    wr(PDS_ADDR_FALL_DT, 32'h0000_01a5);
    apb(1'b0, PDS_ADDR_FALL_DT, 32'h0);
    check(rd, 32'h0000_00a5);
  endtask
  task automatic t_single;
    wr(PDS_ADDR_STEER_SEL, 32'h2d);
    ctl(PDS_MODE_SINGLE, 1'b0, 1'b0, 1'b1);
    pulse(0);
    idle(4);
    check(pins, 6'h2d);
    wr(PDS_ADDR_STEER_SEL, 32'h12);
    idle(3);
    check(pins, 6'h12);
    pulse(1);
    idle(4);
    check(pins, 6'h00);
  endtask
  task automatic t_sync;
    wr(PDS_ADDR_LOAD, 32'h1);
    pulse(2);
    wr(PDS_ADDR_STEER_CTRL, 32'h1);
    pulse(0);
    idle(4);
    check(pins, 6'h12);
    wr(PDS_ADDR_STEER_SEL, 32'h09);
    pulse(2);
    idle(3);
    check(pins, 6'h12);
    wr(PDS_ADDR_LOAD, 32'h1);
    idle(3);
    check(pins, 6'h12);
    pulse(2);
    idle(4);
    check(pins, 6'h09);
    wr(PDS_ADDR_STEER_CTRL, 32'h0);
    pulse(1);
  endtask
  task automatic t_comp;
    ctl(PDS_MODE_COMP, 1'b1, 1'b1, 1'b0);
    wr(PDS_ADDR_RISE_DT, 32'h3);
    wr(PDS_ADDR_FALL_DT, 32'h5);
    wr(PDS_ADDR_STEER_SEL, 32'h03);
    ctl(PDS_MODE_COMP, 1'b1, 1'b1, 1'b1);
    pulse(0);
    idle(12);
    check(gap_hi, 8'h05);
    pulse(1);
    idle(12);
    check(gap_lo, 8'h07);
    wr(PDS_ADDR_RISE_DT, 32'h7);
    pulse(0);
    idle(12);
    check(gap_hi, 8'h05);
    pulse(1);
    idle(12);
    wr(PDS_ADDR_LOAD, 32'h1);
    pulse(2);
    pulse(0);
    idle(14);
    check(gap_hi, 8'h09);
    pulse(1);
    idle(12);
    pulse(0);
    idle(2);
    pulse(1);
    watch(14);
    check(s[0], 1'b0);
    check(out_b, 1'b1);
    pulse(0);
    watch(14);
    pulse(1);
    idle(1);
    pulse(0);
    watch(16);
    check(s[1], 1'b0);
    check(out_a, 1'b1);
    pulse(1);
    idle(1);
    pulse(1);
    idle(14);
    check(gap_lo, 8'h0a);
    check(shoot, 1'b0);
  endtask
  task automatic t_3ph;
    ctl(PDS_MODE_3PH, 1'b0, 1'b0, 1'b1);
    for (int i = 0; i < 6; i++) begin
      wr(PDS_ADDR_STEER_SEL, 32'h1 << i);
      idle(8);
      check(pins, EXP3[i*6 +: 6]);
    end
    wr(PDS_ADDR_STEER_SEL, 32'h0c);
    idle(3);
    check(pins, 6'h24);
    wr(PDS_ADDR_STEER_SEL, 32'h01);
    wr(PDS_ADDR_STEER_CTRL, 32'h2);
    pulse(1);
    idle(4);
    check(pins, 6'h08);
    pulse(0);
    idle(4);
    check(pins, 6'h09);
    wr(PDS_ADDR_STEER_CTRL, 32'h4);
    pulse(1);
    idle(4);
    check(pins, 6'h01);
    ctl(PDS_MODE_FBRIDGE, 1'b0, 1'b0, 1'b1);
    pulse(0);
    idle(4);
    check(pins, 6'h01);
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    clr <= 1'b0;
    t_regs();
    t_single();
    t_sync();
    t_comp();
    t_3ph();
    stop_test();
  end
endmodule
`default_nettype wire
